// File: src/oc_consts.svh
// Register offsets, field positions and reset values of the output compare channel.
`ifndef OC_CONSTS_SVH
`define OC_CONSTS_SVH
`define ADDR_W 8
`define CTRL_OFS 8'h00
`define PRI_OFS 8'h04
`define SEC_OFS 8'h08
`define MODE_LSB 0
`define MODE_MSB 2
`define TSEL_BIT 3
`define FLT_BIT 4
`define IDLE_BIT 13
`define CTRL_RST 16'h0000
`define CMP_RST 16'h0000
`define FAULT_IDLE 1'b1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: src/oc_pkg.sv
// Types and the shared address decode function of the output compare channel.
`include "oc_consts.svh"
package oc_pkg;
   // Compare mode field encodings, in field order.
   typedef enum logic [2:0] {
      MODE_OFF, MODE_SET_HIGH, MODE_SET_LOW, MODE_TOGGLE,
      MODE_ONE_PULSE, MODE_PULSES, MODE_PWM, MODE_PWM_FAULT
   } cmp_mode_t;

   // True for any byte address that holds a register.
   function automatic logic reg_mapped(input logic [`ADDR_W-1:0] a);
      return (a == `CTRL_OFS) || (a == `PRI_OFS) || (a == `SEC_OFS);
   endfunction
endpackage

// File: src/reg_bus_if.sv
// Internal register access path between the bus slave and the channel logic.
`timescale 1ns/1ps
`include "oc_consts.svh"
interface reg_bus_if;
   logic wr_en;
   logic [`ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [`ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   modport slave_end (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
   modport regs_end (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface

// File: src/axil_slave.sv
// AXI4-Lite slave that turns bus transfers into single-cycle register accesses.
`timescale 1ns/1ps
`include "oc_consts.svh"
module axil_slave
   import oc_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Write address and data channels.
   input wire logic [`ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // Write response channel.
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // Read channels.
   input wire logic [`ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side.
   reg_bus_if.slave_end bus
);
   // All slave state; the ready flags are flops computed from the next state.
   typedef struct packed {
      logic aw_got;
      logic [`ADDR_W-1:0] awaddr;
      logic w_got;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic awready;
      logic wready;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } slv_t;

   slv_t s_r;
   slv_t s_nxt;

   // A write commits once both halves are held and no response is pending.
   assign bus.wr_en = s_r.aw_got & s_r.w_got & ~s_r.bvalid;
   assign bus.wr_addr = s_r.awaddr;
   assign bus.wr_data = s_r.wdata;
   assign bus.wr_strb = s_r.wstrb;
   assign bus.rd_addr = araddr;

   // Outputs straight from the state flops.
   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bresp = s_r.bresp;
   assign bvalid = s_r.bvalid;
   assign arready = s_r.arready;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
   assign rvalid = s_r.rvalid;

   // Channel handshakes; address and data are accepted in either order.
   always_comb begin
      s_nxt = s_r;
      if (awvalid && s_r.awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = awaddr;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (bus.wr_en) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = reg_mapped(s_r.awaddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (arvalid && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = bus.rd_data;
         s_nxt.rresp = reg_mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      // Ready is withheld while a response waits, so only one of each is in flight.
      s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
      s_nxt.wready = ~s_nxt.w_got & ~s_nxt.bvalid;
      s_nxt.arready = ~s_nxt.rvalid;
   end

   // State register with synchronous reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

// File: src/output_compare_channel.sv
// Output compare channel: compare modes, PWM with fault, and its register file.
//
// Operation
// - Compare against one or both compare values.
// - Pin changes on compare matches, PWM period starts, faults and mode writes.
// - Mode 000 disables; pin follows general I/O.
// - Mode 001: start low, match sets high.
// - Mode 010: start high, match sets low.
// - Mode 011: keep level, toggle per match.
// - Mode 100: one pulse, interrupt on fall.
// - Mode 101: repeated pulses, interrupt on falls.
// - Mode 110: PWM, fault ignored, no interrupt.
// - Mode 111: PWM, interrupt on fault fall.
// - Fault flag set by hardware, read-only.
// - Idle-stop bit halts channel during CPU idle.
// - Unimplemented control bits read zero.
`timescale 1ns/1ps
`include "oc_consts.svh"
module output_compare_channel
   import oc_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Time bases and system status.
   input wire logic [15:0] timer2_count,
   input wire logic [15:0] timer3_count,
   input wire logic cpu_idle,
   // Active-low fault shared with other channels.
   input wire logic shared_fault_input,
   // Level the general-purpose port would drive.
   input wire logic gpio_pin_level,
   // Pin, interrupt event and status.
   output logic compare_output_pin,
   output logic compare_irq,
   output logic compare_enabled
);
   // All channel state in one record.
   typedef struct packed {
      logic idle_stop;
      logic fault;
      logic tsel;
      cmp_mode_t mode;
      logic [15:0] pri;
      logic [15:0] sec;
      logic [15:0] duty;
      logic level;
      logic done;
      logic eq_pri_d;
      logic eq_sec_d;
      logic zero_d;
      logic fault_in_d;
      logic pin;
      logic irq;
      logic enabled;
   } chan_t;

   // Reset image: control cleared, pin released to general I/O.
   localparam chan_t CHAN_RST = '{
      idle_stop: 1'b0,
      fault: 1'b0,
      tsel: 1'b0,
      mode: MODE_OFF,
      pri: `CMP_RST,
      sec: `CMP_RST,
      duty: `CMP_RST,
      level: 1'b0,
      done: 1'b0,
      eq_pri_d: 1'b0,
      eq_sec_d: 1'b0,
      zero_d: 1'b0,
      fault_in_d: `FAULT_IDLE,
      pin: 1'b0,
      irq: 1'b0,
      enabled: 1'b0
   };

   chan_t s_r;
   chan_t s_nxt;

   // Register access path from the bus slave.
   reg_bus_if bus ();

   // Byte-lane merge used for both compare values.
   function automatic logic [15:0] merge16(
      input logic [15:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction

   // Pin level taken on entry to a mode.
   function automatic logic init_level(
      input cmp_mode_t m,
      input logic cur,
      input logic [15:0] pri
   );
      logic r;
      r = 1'b0;
      case (m)
         MODE_SET_LOW: begin
            r = 1'b1;
         end
         MODE_TOGGLE: begin
            r = cur;
         end
         MODE_PWM, MODE_PWM_FAULT: begin
            r = (pri != 16'h0000);
         end
         default: begin
            r = 1'b0;
         end
      endcase
      return r;
   endfunction

   // Bus slave; its flops drive the bus outputs directly.
   axil_slave u_slave (
      .aclk(aclk),
      .aresetn(aresetn),
      .awaddr(s_axi_awaddr),
      .awvalid(s_axi_awvalid),
      .awready(s_axi_awready),
      .wdata(s_axi_wdata),
      .wstrb(s_axi_wstrb),
      .wvalid(s_axi_wvalid),
      .wready(s_axi_wready),
      .bresp(s_axi_bresp),
      .bvalid(s_axi_bvalid),
      .bready(s_axi_bready),
      .araddr(s_axi_araddr),
      .arvalid(s_axi_arvalid),
      .arready(s_axi_arready),
      .rdata(s_axi_rdata),
      .rresp(s_axi_rresp),
      .rvalid(s_axi_rvalid),
      .rready(s_axi_rready),
      .bus(bus.slave_end)
   );

   // Compare datapath signals.
   logic [15:0] timer;
   logic [15:0] cmp_a;
   logic is_pwm;
   logic halted;
   logic eq_pri;
   logic eq_sec;
   logic at_zero;
   logic match_pri;
   logic match_sec;
   logic period_start;
   logic fault_fall;
   logic wr_ctrl;
   logic wr_pri;
   logic wr_sec;
   logic [15:0] ctrl_view;

   // Timer choice and compare sources.
   assign timer = s_r.tsel ? timer3_count : timer2_count;
   assign is_pwm = (s_r.mode == MODE_PWM) || (s_r.mode == MODE_PWM_FAULT);
   // PWM compares against the latched duty so a mid-period write cannot glitch.
   assign cmp_a = is_pwm ? s_r.duty : s_r.pri;
   assign halted = s_r.idle_stop & cpu_idle;
   assign eq_pri = (timer == cmp_a);
   assign eq_sec = (timer == s_r.sec);
   assign at_zero = (timer == 16'h0000);
   // A match is the first cycle of equality; a stopped timer does not refire.
   assign match_pri = eq_pri & ~s_r.eq_pri_d;
   assign match_sec = eq_sec & ~s_r.eq_sec_d;
   assign period_start = at_zero & ~s_r.zero_d;
   assign fault_fall = s_r.fault_in_d & ~shared_fault_input;

   // Register write decode.
   assign wr_ctrl = bus.wr_en && (bus.wr_addr == `CTRL_OFS);
   assign wr_pri = bus.wr_en && (bus.wr_addr == `PRI_OFS);
   assign wr_sec = bus.wr_en && (bus.wr_addr == `SEC_OFS);

   // Control view with unimplemented positions held at zero.
   always_comb begin
      ctrl_view = `CTRL_RST;
      ctrl_view[`IDLE_BIT] = s_r.idle_stop;
      ctrl_view[`FLT_BIT] = s_r.fault;
      ctrl_view[`TSEL_BIT] = s_r.tsel;
      ctrl_view[`MODE_MSB:`MODE_LSB] = s_r.mode;
   end

   // Read data; unmapped addresses read zero.
   always_comb begin
      case (bus.rd_addr)
         `CTRL_OFS: begin
            bus.rd_data = {16'h0000, ctrl_view};
         end
         `PRI_OFS: begin
            bus.rd_data = {16'h0000, s_r.pri};
         end
         `SEC_OFS: begin
            bus.rd_data = {16'h0000, s_r.sec};
         end
         default: begin
            bus.rd_data = 32'h0000_0000;
         end
      endcase
   end

   // Next state: compare engine first, then software writes, then fault capture.
   always_comb begin
      s_nxt = s_r;
      s_nxt.irq = 1'b0;
      // Halted channels freeze all history, so an equality or fault fall still standing at wake-up fires then.
      if (!halted) begin
         s_nxt.eq_pri_d = eq_pri;
         s_nxt.eq_sec_d = eq_sec;
         s_nxt.zero_d = at_zero;
         s_nxt.fault_in_d = shared_fault_input;
         case (s_r.mode)
            MODE_SET_HIGH: begin
               if (match_pri && !s_r.done) begin
                  s_nxt.level = 1'b1;
                  s_nxt.done = 1'b1;
                  s_nxt.irq = 1'b1;
               end
            end
            MODE_SET_LOW: begin
               if (match_pri && !s_r.done) begin
                  s_nxt.level = 1'b0;
                  s_nxt.done = 1'b1;
                  s_nxt.irq = 1'b1;
               end
            end
            MODE_TOGGLE: begin
               if (match_pri) begin
                  s_nxt.level = ~s_r.level;
                  s_nxt.irq = 1'b1;
               end
            end
            MODE_ONE_PULSE, MODE_PULSES: begin
               // Primary match starts the pulse, secondary match ends it.
               if (!s_r.done) begin
                  if (!s_r.level && match_pri) begin
                     s_nxt.level = 1'b1;
                  end else if (s_r.level && match_sec) begin
                     s_nxt.level = 1'b0;
                     s_nxt.irq = 1'b1;
                     s_nxt.done = (s_r.mode == MODE_ONE_PULSE);
                  end
               end
            end
            MODE_PWM, MODE_PWM_FAULT: begin
               if (s_r.fault) begin
                  s_nxt.level = 1'b0;
               end else if (period_start) begin
                  // New period: latch the next duty from the secondary value.
                  s_nxt.duty = s_r.sec;
                  s_nxt.level = (s_r.sec != 16'h0000);
               end else if (match_pri) begin
                  s_nxt.level = 1'b0;
               end
            end
            default: begin
               s_nxt.done = s_r.done;
            end
         endcase
      end

      // Control write; a low-byte write re-enters the mode and clears the fault.
      if (wr_ctrl) begin
         if (bus.wr_strb[1]) begin
            s_nxt.idle_stop = bus.wr_data[`IDLE_BIT];
         end
         if (bus.wr_strb[0]) begin
            s_nxt.mode = cmp_mode_t'(bus.wr_data[`MODE_MSB:`MODE_LSB]);
            s_nxt.tsel = bus.wr_data[`TSEL_BIT];
            s_nxt.done = 1'b0;
            s_nxt.fault = 1'b0;
            s_nxt.duty = s_r.pri;
            s_nxt.level = init_level(s_nxt.mode, s_r.level, s_r.pri);
            // Fresh mode takes an equality already standing as a new match, but not a standing zero.
            s_nxt.eq_pri_d = 1'b0;
            s_nxt.eq_sec_d = 1'b0;
            s_nxt.zero_d = 1'b1;
         end
      end
      if (wr_pri) begin
         s_nxt.pri = merge16(s_r.pri, bus.wr_data, bus.wr_strb);
      end
      if (wr_sec) begin
         s_nxt.sec = merge16(s_r.sec, bus.wr_data, bus.wr_strb);
      end

      // Fault capture last so it wins over a clear in the same cycle.
      if (!halted && s_r.mode == MODE_PWM_FAULT && fault_fall) begin
         s_nxt.fault = 1'b1;
         s_nxt.level = 1'b0;
         s_nxt.irq = 1'b1;
      end

      // Disabled channel hands the pin to the general-purpose port.
      s_nxt.enabled = (s_nxt.mode != MODE_OFF);
      s_nxt.pin = s_nxt.enabled ? s_nxt.level : gpio_pin_level;
   end

   // State register with synchronous reset.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= CHAN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from the state flops.
   assign compare_output_pin = s_r.pin;
   assign compare_irq = s_r.irq;
   assign compare_enabled = s_r.enabled;
endmodule

// File: verification/oc_properties.sv
// Concurrent checks on the ports of the output compare channel.
`timescale 1ns/1ps
`include "oc_consts.svh"
module oc_properties (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels.
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Read channels.
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Channel side.
   input wire logic [15:0] timer2_count,
   input wire logic [15:0] timer3_count,
   input wire logic cpu_idle,
   input wire logic shared_fault_input,
   input wire logic gpio_pin_level,
   input wire logic compare_output_pin,
   input wire logic compare_irq,
   input wire logic compare_enabled
);
   logic [`ADDR_W-1:0] rd_addr_r; // Address of the read in flight.
   logic [1:0] wr_seen_r; // Recent data handshakes; the pin may lag a commit.
   // Track the read address and recent writes for the checks below.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_r <= '0;
         wr_seen_r <= 2'h0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_r <= s_axi_araddr;
         end
         wr_seen_r <= {wr_seen_r[0], s_axi_wvalid && s_axi_wready};
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_in_two;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   a_wr_resp_time: assert property (wr_taken |=> resp_in_two)
      else $error("write response not two edges after the transfer");
   a_rd_resp_time: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one edge after the address");
   a_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped before taken");
   a_ctrl_zero_bits: assert property (s_axi_rvalid && rd_addr_r == `CTRL_OFS |->
      s_axi_rdata[31:14] == 18'h0 && s_axi_rdata[12:5] == 8'h00)
      else $error("unimplemented control bits read nonzero");
   a_unmapped_read: assert property (s_axi_rvalid && rd_addr_r != `CTRL_OFS &&
      rd_addr_r != `PRI_OFS && rd_addr_r != `SEC_OFS |->
      s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read answered");
   a_irq_single: assert property (compare_irq |=> !compare_irq)
      else $error("interrupt event longer than one cycle");
   a_off_no_irq: assert property (!compare_enabled && !$past(compare_enabled) |->
      !compare_irq) else $error("interrupt while disabled");
   a_gpio_follow: assert property ($past(aresetn) && wr_seen_r == 2'h0 &&
      !compare_enabled && !$past(compare_enabled) |-> compare_output_pin == $past(gpio_pin_level))
      else $error("disabled pin does not follow the port level");
   a_irq_on_rise: assert property (compare_irq && compare_output_pin |->
      !$past(compare_output_pin)) else $error("interrupt with high pin but no rising edge");
endmodule
bind output_compare_channel oc_properties props (.*);

// File: verification/pin_load.sv
// Load on the compare pin that counts the rising edges it sees.
`timescale 1ns/1ps
module pin_load (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Pin driven by the channel.
   input wire logic pin,
   // Rising edges seen since reset.
   output logic [7:0] rise_count
);
   logic prev_r; // Pin level at the previous edge.
   // Sampled like a synchronous input stage, so a one-cycle glitch still counts.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b0;
         rise_count <= 8'h00;
      end else begin
         prev_r <= pin;
         if (pin && !prev_r) begin
            rise_count <= rise_count + 8'h01;
         end
      end
   end
endmodule

// File: verification/output_compare_channel_tb.sv
// Self-checking bench of the output compare channel.
`timescale 1ns/1ps
`include "oc_consts.svh"
module output_compare_channel_tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [`ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [15:0] timer2_count, timer3_count;
   logic cpu_idle, shared_fault_input, gpio_pin_level;
   logic compare_output_pin, compare_irq, compare_enabled;
   logic [7:0] rise_count; // Edges counted by the load.
   int miscompares = 0;
   int n_tests = 0;
   integer seed = 43;
   output_compare_channel DUT (.*);
   pin_load load (.aclk(aclk), .aresetn(aresetn), .pin(compare_output_pin), .rise_count(rise_count));
   // Free-running bus clock.
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic pi(input logic p, input logic i);
      chk({30'h0, compare_output_pin, compare_irq}, {30'h0, p, i});
   endtask
   // One write; address and data go together and each is released when taken.
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   // Timer shows the value for one cycle, then parks at a value never compared.
   task automatic hit(input logic sel, input logic [15:0] v);
      @(posedge aclk);
      if (sel) timer3_count <= v;
      else timer2_count <= v;
      @(posedge aclk);
      timer2_count <= 16'hFFFF;
      timer3_count <= 16'hFFFF;
      #1;
   endtask
   // The fall is taken at the next edge, so look while its one-cycle interrupt stands.
   task automatic fault_fall();
      @(posedge aclk);
      shared_fault_input <= 1'b0;
      @(posedge aclk);
      #1;
   endtask
   function automatic logic [15:0] rv();
      return 16'h0001 + 16'($unsigned($random(seed)) % 32'h0000FFFD);
   endfunction
   // Pin level that a mode write must leave behind.
   function automatic logic init_pin(input int m, input logic cur, input logic [15:0] pri);
      case (m)
         2: return 1'b1;
         3: return cur;
         6, 7: return pri != 16'h0000;
         default: return 1'b0;
      endcase
   endfunction
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Cuts a hang short; the whole sequence needs a few hundred cycles.
   initial begin
      #400000;
      miscompares++;
      close_out();
   end
   initial begin
      logic [15:0] p, q;
      logic s, ep;
      logic [7:0] r0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      {timer2_count, timer3_count} = 32'hFFFFFFFF;
      {cpu_idle, gpio_pin_level} = 2'h0;
      shared_fault_input = 1'b1;
      aresetn = 1'b0;
      ep = 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, the map and the read-only and unused control bits.
      rd(`CTRL_OFS, 32'h0, `RESP_OKAY);
      rd(`SEC_OFS, 32'h0, `RESP_OKAY);
      rd(8'h0C, 32'h0, `RESP_SLVERR);
      rd(8'h02, 32'h0, `RESP_SLVERR);
      wr(8'h0C, 16'h1234, `RESP_SLVERR);
      wr(`CTRL_OFS, 16'hFFFF, `RESP_OKAY);
      rd(`CTRL_OFS, 32'h0000200F, `RESP_OKAY);
      // Single-value modes, on a random time base, with a match on the other timer.
      for (int m = 1; m < 4; m++) begin
         p = rv();
         s = 1'($random(seed));
         wr(`PRI_OFS, p, `RESP_OKAY);
         wr(`CTRL_OFS, {12'h000, s, 3'(m)}, `RESP_OKAY);
         ep = init_pin(m, ep, p);
         pi(ep, 1'b0);
         chk({31'h0, compare_enabled}, 32'h1);
         hit(!s, p);
         pi(ep, 1'b0);
         hit(s, p);
         ep = (m == 3) ? !ep : (m == 1);
         pi(ep, 1'b1);
         hit(s, p);
         if (m == 3) ep = !ep;
         pi(ep, m == 3);
      end
      rd(`PRI_OFS, {16'h0000, p}, `RESP_OKAY);
      // Pulse modes bounded by both compare values.
      for (int m = 4; m < 6; m++) begin
         p = rv();
         do q = rv(); while (q == p);
         wr(`SEC_OFS, q, `RESP_OKAY);
         wr(`PRI_OFS, p, `RESP_OKAY);
         wr(`CTRL_OFS, 16'(m), `RESP_OKAY);
         pi(1'b0, 1'b0);
         r0 = rise_count;
         for (int k = 0; k < 2; k++) begin
            hit(1'b0, p);
            pi(k == 0 || m == 5, 1'b0);
            hit(1'b0, q);
            pi(1'b0, k == 0 || m == 5);
         end
         if (m == 5) chk({24'h0, rise_count - r0}, 32'h2);
      end
      // Plain PWM: duty from the primary, period start reloads from the secondary.
      wr(`CTRL_OFS, 16'h0006, `RESP_OKAY);
      pi(init_pin(6, ep, p), 1'b0);
      hit(1'b0, p);
      pi(1'b0, 1'b0);
      hit(1'b0, 16'h0000);
      pi(1'b1, 1'b0);
      hit(1'b0, q);
      pi(1'b0, 1'b0);
      fault_fall();
      chk({31'h0, compare_irq}, 32'h0);
      shared_fault_input <= 1'b1;
      // PWM with protection: a fault forces the pin low until the mode is rewritten.
      wr(`CTRL_OFS, 16'h0007, `RESP_OKAY);
      pi(1'b1, 1'b0);
      fault_fall();
      pi(1'b0, 1'b1);
      rd(`CTRL_OFS, 32'h00000017, `RESP_OKAY);
      hit(1'b0, 16'h0000);
      pi(1'b0, 1'b0);
      shared_fault_input <= 1'b1;
      wr(`CTRL_OFS, 16'h0007, `RESP_OKAY);
      pi(1'b1, 1'b0);
      rd(`CTRL_OFS, 32'h00000007, `RESP_OKAY);
      // Idle stop: frozen while the processor idles, running when the bit is clear.
      // Toggle mode compares the primary value, so each hit below is a real match.
      ep = 1'b1;
      wr(`CTRL_OFS, 16'h2003, `RESP_OKAY);
      @(posedge aclk);
      cpu_idle <= 1'b1;
      hit(1'b0, p);
      pi(ep, 1'b0);
      @(posedge aclk);
      cpu_idle <= 1'b0;
      hit(1'b0, p);
      ep = !ep;
      pi(ep, 1'b1);
      wr(`CTRL_OFS, 16'h0003, `RESP_OKAY);
      @(posedge aclk);
      cpu_idle <= 1'b1;
      hit(1'b0, p);
      pi(!ep, 1'b1);
      // Disabled: the pin shows the port level and matches do nothing.
      wr(`CTRL_OFS, 16'h0000, `RESP_OKAY);
      repeat (4) begin
         @(posedge aclk);
         gpio_pin_level <= 1'($random(seed));
         repeat (2) @(posedge aclk);
         #1;
         chk({31'h0, compare_output_pin}, {31'h0, gpio_pin_level});
      end
      hit(1'b0, q);
      chk({30'h0, compare_irq, compare_enabled}, 32'h0);
      close_out();
   end
endmodule
